// File: src/lspg_map.vh
// constants for the status LED pattern generator: timing, map, modes
`ifndef LSPG_MAP_VH
`define LSPG_MAP_VH

// timing base
`define LSPG_CLK_PERIOD_NS   10
`define LSPG_MS_NS           1000000
`define LSPG_MS_CYC          ((`LSPG_MS_NS + `LSPG_CLK_PERIOD_NS - 1) / `LSPG_CLK_PERIOD_NS)
`define LSPG_SLOT_MS         250
`define LSPG_FRAME_MS        3000
`define LSPG_FRAME_SLOTS     (`LSPG_FRAME_MS / `LSPG_SLOT_MS)
`define LSPG_BLINK5_MS       100
`define LSPG_FLICK_MS        50

// register byte addresses
`define LSPG_ADDR_CTRL       8'h00
`define LSPG_ADDR_STATUS     8'h04
`define LSPG_ADDR_ERR_CLR    8'h08

// control register fields
`define LSPG_CTRL_MODE_LSB   0
`define LSPG_CTRL_MODE_MSB   3
`define LSPG_CTRL_COLA_LSB   4
`define LSPG_CTRL_COLA_MSB   5
`define LSPG_CTRL_COLB_LSB   6
`define LSPG_CTRL_COLB_MSB   7
`define LSPG_CTRL_RESET      8'h00
`define LSPG_ERR_CLR_BIT     0

// colour codes {red, green}
`define LSPG_COL_OFF         2'h0
`define LSPG_COL_GREEN       2'h1
`define LSPG_COL_RED         2'h2
`define LSPG_COL_ORANGE      2'h3

// slave indicator modes
`define LSPG_MODE_STEADY     4'h0
`define LSPG_MODE_FLASH1     4'h1
`define LSPG_MODE_FLASH2     4'h2
`define LSPG_MODE_SLOW_A     4'h3
`define LSPG_MODE_SLOW_B     4'h4
`define LSPG_MODE_SLOW_C     4'h5
`define LSPG_MODE_SLOW_D     4'h6

// green-slot masks for the 3 s frames, bit n = slot n green, else orange
`define LSPG_MASK_SLOW_A     12'h001
`define LSPG_MASK_SLOW_B     12'hFFA
`define LSPG_MASK_SLOW_C     12'h015
`define LSPG_MASK_SLOW_D     12'hFFE

`endif

// File: src/lspg_flicker.v
// load-dependent flicker for one port activity indicator
`timescale 1ns/10ps
`default_nettype none
`include "lspg_map.vh"

module lspg_flicker (
  // clock and reset
  input  wire clk_sys_in,
  input  wire nrst_in,
  // timing and activity
  input  wire ms_tick_in,
  input  wire frame_evt_in,
  // indicator
  output reg  led_q_out
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ON   = 2'h1;
  localparam [1:0] ST_OFF  = 2'h2;
  localparam integer PH_LAST_I = `LSPG_FLICK_MS - 1;
  localparam [7:0]   PH_LAST   = PH_LAST_I[7:0];

  reg [1:0] state_q;
  reg [7:0] cnt_q;
  reg       pend_q;
  wire      ph_done = ms_tick_in && (cnt_q == PH_LAST);

  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 8'h00;
      pend_q    <= 1'b0;
      led_q_out <= 1'b0;
    end else begin
      if (ms_tick_in)
        cnt_q <= ph_done ? 8'h00 : cnt_q + 8'h01;
      case (state_q)
        ST_IDLE: begin
          // light traffic: each frame starts one on/off pair
          if (frame_evt_in) begin
            state_q   <= ST_ON;
            cnt_q     <= 8'h00;
            led_q_out <= 1'b1;
          end
        end
        ST_ON: begin
          if (frame_evt_in)
            pend_q <= 1'b1;
          if (ph_done) begin
            state_q   <= ST_OFF;
            led_q_out <= 1'b0;
          end
        end
        ST_OFF: begin
          // a frame in the last cycle still counts: it starts the next on phase directly while pend_q clears
          if (ph_done) begin
            if (pend_q || frame_evt_in) begin
              state_q   <= ST_ON;
              led_q_out <= 1'b1;
            end else begin
              state_q   <= ST_IDLE;
            end
            pend_q <= 1'b0;
          end else if (frame_evt_in) begin
            pend_q <= 1'b1;
          end
        end
        default: begin
          state_q   <= ST_IDLE;
          led_q_out <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// File: src/lspg_top.v
// status LED pattern generator: slave duo LED, client run/error, port LEDs
// What this block does
// - single-colour 2 Hz flash, on 250 ms then off 250 ms, repeating.
// - two-colour 2 Hz flash, colour A 250 ms then colour B 250 ms.
// - green 250 ms then orange 2.75 s, three-second frame.
// - orange, green, orange 250 ms each, then green 2.25 s.
// - green, orange, green, orange, green 250 ms each, orange 1.75 s.
// - orange 250 ms then green 2.75 s, three-second frame.
// - heavy traffic flickers 50 ms on/off; light traffic follows frames.
// - run LED steady green configured and active, off unconfigured.
// - run LED blinks green 5 Hz when configured but inactive.
// - 5 Hz blink is 100 ms on then 100 ms off.
// - per-port link LED green while linked, off otherwise.
// - per-port activity LED flickers yellow while frames move.
`timescale 1ns/10ps
`default_nettype none
`include "lspg_map.vh"

module lspg_top #(
  parameter MS_CYCLES = `LSPG_MS_CYC
) (
  // clock and reset
  input  wire        clk_sys_in,
  input  wire        nrst_in,
  // register port
  input  wire [7:0]  reg_addr_in,
  input  wire [31:0] reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [31:0] reg_rdata_out,
  // protocol stack status, same clock
  input  wire        dev_configured_in,
  input  wire        comm_active_in,
  input  wire        comm_error_in,
  // port status pins, asynchronous
  input  wire [1:0]  port_link_in,
  input  wire [1:0]  port_frame_in,
  // slave duo LED
  output reg         slave_led_red_out,
  output reg         slave_led_green_out,
  // client run and error duo LEDs
  output reg         run_led_red_out,
  output reg         run_led_green_out,
  output reg         err_led_red_out,
  output reg         err_led_green_out,
  // port LEDs
  output reg  [1:0]  port_link_led_out,
  output wire        port0_traffic_indicator_out,
  output wire        port1_traffic_indicator_out
);

  // counter end points cut to counter width on purpose
  localparam integer MS_LAST_I    = MS_CYCLES - 1;
  localparam integer SLOT_LAST_I  = `LSPG_SLOT_MS - 1;
  localparam integer FRAME_LAST_I = `LSPG_FRAME_SLOTS - 1;
  localparam integer B5_LAST_I    = `LSPG_BLINK5_MS - 1;
  localparam [16:0]  MS_LAST      = MS_LAST_I[16:0];
  localparam [7:0]   SLOT_LAST    = SLOT_LAST_I[7:0];
  localparam [3:0]   FRAME_LAST   = FRAME_LAST_I[3:0];
  localparam [6:0]   B5_LAST      = B5_LAST_I[6:0];

  // green-slot lookup for the slow-frame modes
  function slot_green;
    input [3:0] mode;
    input [3:0] slot;
    reg   [11:0] mask;
    begin
      case (mode)
        `LSPG_MODE_SLOW_A: mask = `LSPG_MASK_SLOW_A;
        `LSPG_MODE_SLOW_B: mask = `LSPG_MASK_SLOW_B;
        `LSPG_MODE_SLOW_C: mask = `LSPG_MASK_SLOW_C;
        `LSPG_MODE_SLOW_D: mask = `LSPG_MASK_SLOW_D;
        default:           mask = 12'h000;
      endcase
      slot_green = mask[slot];
    end
  endfunction

  // registers
  reg  [7:0]  ctrl_q;
  reg         err_seen_q;
  wire [3:0]  mode    = ctrl_q[`LSPG_CTRL_MODE_MSB:`LSPG_CTRL_MODE_LSB];
  wire [1:0]  col_a   = ctrl_q[`LSPG_CTRL_COLA_MSB:`LSPG_CTRL_COLA_LSB];
  wire [1:0]  col_b   = ctrl_q[`LSPG_CTRL_COLB_MSB:`LSPG_CTRL_COLB_LSB];
  wire        wr_ctrl = reg_wr_in && (reg_addr_in == `LSPG_ADDR_CTRL);
  wire        wr_eclr = reg_wr_in && (reg_addr_in == `LSPG_ADDR_ERR_CLR) &&
                        reg_wdata_in[`LSPG_ERR_CLR_BIT];

  // synchronised port pins
  reg  [1:0]  link_s1_q;
  reg  [1:0]  link_s2_q;
  reg  [1:0]  frame_s1_q;
  reg  [1:0]  frame_s2_q;
  reg  [1:0]  frame_s3_q;
  wire [1:0]  frame_evt = frame_s2_q & ~frame_s3_q;
  wire [1:0]  traffic_led;

  // timebase
  reg  [16:0] ms_cnt_q;
  reg         ms_tick_q;
  reg  [7:0]  slot_ms_q;
  reg  [3:0]  slot_q;
  reg  [6:0]  b5_ms_q;
  reg         b5_on_q;

  // pattern colour for the slave LED
  reg  [1:0]  slave_col;

  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ctrl_q     <= `LSPG_CTRL_RESET;
      err_seen_q <= 1'b0;
    end else begin
      if (wr_ctrl)
        ctrl_q <= reg_wdata_in[7:0];
      // a new error in the clearing cycle keeps the flag set
      if (comm_error_in)
        err_seen_q <= 1'b1;
      else if (wr_eclr)
        err_seen_q <= 1'b0;
    end
  end

  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `LSPG_ADDR_CTRL:
          reg_rdata_out <= {24'h00_0000, ctrl_q};
        `LSPG_ADDR_STATUS:
          reg_rdata_out <= {18'h0_0000,
                            port1_traffic_indicator_out,
                            port0_traffic_indicator_out,
                            port_link_led_out,
                            slave_led_red_out,
                            slave_led_green_out,
                            err_seen_q,
                            b5_on_q,
                            slot_q,
                            comm_active_in,
                            dev_configured_in};
        default:
          reg_rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
      always @(posedge clk_sys_in) begin
        if (!nrst_in) begin
          link_s1_q[p]  <= 1'b0;
          link_s2_q[p]  <= 1'b0;
          frame_s1_q[p] <= 1'b0;
          frame_s2_q[p] <= 1'b0;
          frame_s3_q[p] <= 1'b0;
          port_link_led_out[p] <= 1'b0;
        end else begin
          link_s1_q[p]  <= port_link_in[p];
          link_s2_q[p]  <= link_s1_q[p];
          frame_s1_q[p] <= port_frame_in[p];
          frame_s2_q[p] <= frame_s1_q[p];
          frame_s3_q[p] <= frame_s2_q[p];
          port_link_led_out[p] <= link_s2_q[p];
        end
      end

      // each port flickers from its own frames only
      lspg_flicker u_flick (
        .clk_sys_in   (clk_sys_in),
        .nrst_in      (nrst_in),
        .ms_tick_in   (ms_tick_q),
        .frame_evt_in (frame_evt[p]),
        .led_q_out    (traffic_led[p])
      );
    end
  endgenerate

  assign port0_traffic_indicator_out = traffic_led[0];
  assign port1_traffic_indicator_out = traffic_led[1];

  // one shared ms tick keeps every pattern phase-locked
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ms_cnt_q  <= 17'h0_0000;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= (ms_cnt_q == MS_LAST);
      if (ms_cnt_q == MS_LAST)
        ms_cnt_q <= 17'h0_0000;
      else
        ms_cnt_q <= ms_cnt_q + 17'h0_0001;
    end
  end

  // 250 ms slots, twelve to a 3 s frame
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      slot_ms_q <= 8'h00;
      slot_q    <= 4'h0;
    end else if (ms_tick_q) begin
      if (slot_ms_q == SLOT_LAST) begin
        slot_ms_q <= 8'h00;
        slot_q    <= (slot_q == FRAME_LAST) ? 4'h0 : slot_q + 4'h1;
      end else begin
        slot_ms_q <= slot_ms_q + 8'h01;
      end
    end
  end

  // 5 Hz: 100 ms on, 100 ms off
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      b5_ms_q <= 7'h00;
      b5_on_q <= 1'b1;
    end else if (ms_tick_q) begin
      if (b5_ms_q == B5_LAST) begin
        b5_ms_q <= 7'h00;
        b5_on_q <= ~b5_on_q;
      end else begin
        b5_ms_q <= b5_ms_q + 7'h01;
      end
    end
  end

  // slave duo LED colour; orange drives red and green together
  always @* begin
    case (mode)
      `LSPG_MODE_STEADY:
        slave_col = col_a;
      `LSPG_MODE_FLASH1:
        slave_col = slot_q[0] ? `LSPG_COL_OFF : col_a;
      `LSPG_MODE_FLASH2:
        slave_col = slot_q[0] ? col_b : col_a;
      `LSPG_MODE_SLOW_A,
      `LSPG_MODE_SLOW_B,
      `LSPG_MODE_SLOW_C,
      `LSPG_MODE_SLOW_D:
        slave_col = slot_green(mode, slot_q) ? `LSPG_COL_GREEN :
                                               `LSPG_COL_ORANGE;
      default:
        slave_col = `LSPG_COL_OFF;
    endcase
  end

  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      slave_led_red_out   <= 1'b0;
      slave_led_green_out <= 1'b0;
    end else begin
      slave_led_red_out   <= slave_col[1];
      slave_led_green_out <= slave_col[0];
    end
  end

  // client run and error LEDs
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      run_led_red_out   <= 1'b0;
      run_led_green_out <= 1'b0;
      err_led_red_out   <= 1'b0;
      err_led_green_out <= 1'b0;
    end else begin
      run_led_red_out   <= 1'b0;
      err_led_green_out <= 1'b0;
      if (!dev_configured_in)
        run_led_green_out <= 1'b0;
      else if (comm_active_in)
        run_led_green_out <= 1'b1;
      else
        run_led_green_out <= b5_on_q;
      // a remembered error outranks the unconfigured blink
      if (err_seen_q || comm_error_in)
        err_led_red_out <= 1'b1;
      else if (!dev_configured_in)
        err_led_red_out <= b5_on_q;
      else
        err_led_red_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: tb/lspg_top_properties.sv
// port checker for the status LED pattern generator
`timescale 1ns/10ps
`default_nettype none
`include "lspg_map.vh"
module lspg_top_props #(parameter int MS_CYCLES = 10) (
  // clock, reset and watched pins
  input wire logic        clk_sys_in,
  input wire logic        nrst_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        dev_configured_in,
  input wire logic        comm_active_in,
  input wire logic        comm_error_in,
  input wire logic [1:0]  port_link_in,
  input wire logic        run_led_red_out,
  input wire logic        run_led_green_out,
  input wire logic        err_led_red_out,
  input wire logic        err_led_green_out,
  input wire logic [1:0]  port_link_led_out,
  input wire logic        port0_traffic_indicator_out
);
  localparam int FLK_MAX = 50 * MS_CYCLES + 2;
  logic [2:0] up_q;
  wire        p0 = port0_traffic_indicator_out;
  wire        clr = reg_wr_in && reg_wdata_in[0]
                    && reg_addr_in == `LSPG_ADDR_ERR_CLR;
  // link syncs still hold reset values just after release
  always @(posedge clk_sys_in) begin
    if (!nrst_in) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  sequence s_err_hit;
    comm_error_in ##1 !clr [*8];
  endsequence
  sequence s_err_gone;
    clr && !comm_error_in && dev_configured_in ##1
      dev_configured_in && !comm_error_in;
  endsequence
  AST_RUN_OFF:
    assert property (!dev_configured_in |=> !run_led_green_out)
    else $error("run led lit while unconfigured");
  AST_RUN_ON:
    assert property (dev_configured_in && comm_active_in |=> run_led_green_out)
    else $error("run led dark while active");
  AST_UNUSED_PINS:
    assert property (!run_led_red_out && !err_led_green_out)
    else $error("unused colour lit");
  AST_ERR_SET:
    assert property (s_err_hit |-> err_led_red_out)
    else $error("error led not held red");
  AST_ERR_CLR:
    assert property (s_err_gone |=> !err_led_red_out)
    else $error("error led lit while configured");
  AST_LINK:
    assert property (up_q == 3'h7 |->
                     port_link_led_out == $past(port_link_in, 3))
    else $error("link led does not follow link");
  AST_FLK_ON:
    assert property ($rose(p0) |=> p0 [*8])
    else $error("activity flash too short");
  AST_FLK_END:
    assert property ($rose(p0) |-> ##[1:FLK_MAX] !p0)
    else $error("activity flash too long");
  AST_FLK_GAP:
    assert property ($fell(p0) |=> !p0 [*8])
    else $error("activity gap too short");
endmodule
`default_nettype wire

// File: tb/lspg_led_watch.sv
// front panel lamp: length of each finished lit or dark run
`timescale 1ns/10ps
`default_nettype none
module lspg_led_watch (
  input  wire logic       clk_sys_in,
  input  wire logic [1:0] led_in,
  output var  int         run_len_out,
  output var  int         runs_out
);
  int         cnt = 0;
  logic [1:0] prev = 2'h0;
  initial run_len_out = 0;
  initial runs_out = 0;
  always @(posedge clk_sys_in) begin
    cnt <= (led_in !== prev) ? 1 : cnt + 1;
    if (led_in !== prev) begin
      run_len_out <= cnt;
      runs_out    <= runs_out + 1;
      prev        <= led_in;
    end
  end
endmodule
`default_nettype wire

// File: tb/tb.sv
// bench for the status LED pattern generator
`timescale 1ns/10ps
`default_nettype none
`include "lspg_map.vh"
module tb;
  // short ms keeps a 3 s frame at 6000 clocks
  localparam int MS = 2;
  localparam int SLOT = 250 * MS;
  localparam int BLK = 100 * MS;
  localparam int FLO = 49 * MS - 1;
  localparam int FHI = 50 * MS + 1;
  logic        clk_sys_in, nrst_in, reg_wr_in, reg_rd_in;
  logic        dev_configured_in, comm_active_in, comm_error_in;
  logic [7:0]  reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, d;
  logic [1:0]  port_link_in, port_frame_in, port_link_led_out, a, b, e;
  logic        slave_led_red_out, slave_led_green_out, run_led_red_out;
  logic        run_led_green_out, err_led_red_out, err_led_green_out;
  logic        port0_traffic_indicator_out, port1_traffic_indicator_out;
  logic [15:0] lfsr;
  int          n_fail, checks, r0, sl, rn, er, er_n, p0, p1, x;
  wire  [1:0]  col = {slave_led_red_out, slave_led_green_out};
  lspg_top #(.MS_CYCLES(MS)) lspg_top_i (.*);
  lspg_led_watch sl_w (.clk_sys_in, .led_in(col), .run_len_out(sl),
    .runs_out(x));
  lspg_led_watch rn_w (.clk_sys_in, .led_in({1'b0, run_led_green_out}),
    .run_len_out(rn), .runs_out());
  lspg_led_watch er_w (.clk_sys_in, .led_in({err_led_red_out, 1'b0}),
    .run_len_out(er), .runs_out(er_n));
  lspg_led_watch p0_w (.clk_sys_in, .run_len_out(p0), .runs_out(),
    .led_in({1'b0, port0_traffic_indicator_out}));
  lspg_led_watch p1_w (.clk_sys_in, .run_len_out(p1), .runs_out(),
    .led_in({1'b0, port1_traffic_indicator_out}));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // slot colour of each slave mode, slot 0 first
  function automatic logic [1:0] exp_col(input int m, input logic [3:0] s);
    logic [1:0] g;
    logic [1:0] o;
    g = `LSPG_COL_GREEN;
    o = `LSPG_COL_ORANGE;
    case (m)
      0: return a;
      1: return s[0] ? `LSPG_COL_OFF : a;
      2: return s[0] ? b : a;
      3: return (s == 4'h0) ? g : o;
      4: return (s == 4'h0 || s == 4'h2) ? o : g;
      5: return (s < 4'h5 && !s[0]) ? g : o;
      6: return (s == 4'h0) ? o : g;
      default: return `LSPG_COL_OFF;
    endcase
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge clk_sys_in);
    reg_addr_in <= ad;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clk_sys_in);
    reg_addr_in <= ad;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  task automatic frame(input logic [1:0] p, input int gap);
    port_frame_in <= p;
    tick(2);
    port_frame_in <= 2'h0;
    tick(gap);
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_len(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("unexpected at %0t: run %0d outside %0d..%0d",
               $time, got, lo, hi);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // the tests need about 57000 clocks
  initial begin
    #900000;
    n_fail++;
    complete_run;
  end
  initial begin
    {nrst_in, reg_wr_in, reg_rd_in, comm_error_in} = 4'h0;
    {dev_configured_in, comm_active_in, reg_addr_in, reg_wdata_in} = '0;
    {port_link_in, port_frame_in} = 4'h0;
    {lfsr, n_fail, checks} = {16'h0041, 64'h0};
    tick(4);
    nrst_in <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      lfsr = nxt(lfsr);
      a = (lfsr[1:0] == 2'h0) ? 2'h1 : lfsr[1:0];
      b = a ^ 2'h3;
      wr(`LSPG_ADDR_CTRL, {24'h0, b, a, m[3:0]});
      wr(8'h0C, {16'h0, lfsr});
      rd(`LSPG_ADDR_CTRL);
      chk_val(d, {24'h0, b, a, m[3:0]});
      rd(`LSPG_ADDR_STATUS);
      r0 = d[5:2];
      for (int k = 0; k < 400 && d[5:2] == r0; k++) rd(`LSPG_ADDR_STATUS);
      tick(SLOT / 2);
      for (int i = 0; i < 12; i++) begin
        rd(`LSPG_ADDR_STATUS);
        e = exp_col(m, d[5:2]);
        chk_val(col, e);
        tick(SLOT - 2);
      end
      if (m == 1 || m == 2) chk_len(sl, SLOT, SLOT);
      $display("test slave mode %0d done", m);
    end
    for (int c = 0; c < 4; c++) begin
      dev_configured_in <= c[1];
      comm_active_in <= c[0];
      wr(`LSPG_ADDR_ERR_CLR, 32'h1);
      tick(5 * BLK / 2);
      if (c == 2) chk_len(rn, BLK, BLK);
      else chk_val(run_led_green_out, c == 3);
      if (c < 2) chk_len(er, BLK, BLK);
      else chk_val(err_led_red_out, 1'b0);
    end
    comm_error_in <= 1'b1;
    tick(1);
    comm_error_in <= 1'b0;
    dev_configured_in <= 1'b0;
    tick(5);
    r0 = er_n;
    tick(3 * BLK);
    chk_val(err_led_red_out, 1'b1);
    chk_len(er_n, r0, r0);
    dev_configured_in <= 1'b1;
    wr(`LSPG_ADDR_ERR_CLR, 32'h1);
    tick(3);
    chk_val(err_led_red_out, 1'b0);
    $display("test run and error indicators done");
    for (int i = 0; i < 6; i++) begin
      lfsr = nxt(lfsr);
      port_link_in <= lfsr[1:0];
      tick(5);
      chk_val(port_link_led_out, lfsr[1:0]);
    end
    for (int i = 0; i < 40; i++) begin
      lfsr = nxt(lfsr);
      frame(2'h3, 10 + lfsr[3:0]);
    end
    chk_len(p0, FLO, FHI);
    chk_len(p1, FLO, FHI);
    tick(4 * FHI);
    e = {port1_traffic_indicator_out, port0_traffic_indicator_out};
    chk_val(e, 32'h0);
    for (int i = 0; i < 3; i++) begin
      lfsr = nxt(lfsr);
      frame(2'h1, 3 * FHI + lfsr[6:0]);
      chk_len(p0, FLO, FHI);
      chk_val(port1_traffic_indicator_out, 1'b0);
    end
    $display("test link and activity indicators done");
    complete_run;
  end
endmodule
bind lspg_top lspg_top_props #(.MS_CYCLES(MS_CYCLES)) lspg_top_props_i (.*);
`default_nettype wire
